// ===== core/drs_pkg.sv
// Package: constants and types for the dual output reset supervisor
package drs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS  = 4000;          // 250 MHz clock period
    localparam int unsigned TIMEOUT_MS     = 140;           // Least recovery timeout
    localparam longint unsigned TIMEOUT_CYC =
        (longint'(TIMEOUT_MS) * 64'd1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Extended setup options, in milliseconds
    localparam int unsigned SETUP_K_MS = 10080;
    localparam int unsigned SETUP_L_MS = 6720;
    localparam int unsigned SETUP_S_MS = 3360;
    localparam int unsigned SETUP_T_MS = 1680;

    localparam int CNT_W = 32;                              // Counter width
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DRS_SETUP_K = 2'h0,
        DRS_SETUP_L = 2'h1,
        DRS_SETUP_S = 2'h2,
        DRS_SETUP_T = 2'h3
    } drs_setup_e;

    // Hold timer state machine, one-hot
    typedef enum logic [2:0] {
        DRS_ACTIVE  = 3'h1,                                 // Cause present
        DRS_HOLD    = 3'h2,                                 // Counting timeout
        DRS_IDLE    = 3'h4                                  // Released
    } drs_state_e;

    // Synchronised inputs travel together
    typedef struct packed {
        logic vcc_low;
        logic aux_low;
        logic button;                                       // High while pressed
    } drs_in_s;

    // Cycles for an extended setup period, least time rounded up
    function automatic longint unsigned drs_setup_cyc(input int unsigned ms);
        return (longint'(ms) * 64'd1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    endfunction

endpackage

// ===== core/drs_supervisor.sv
// Top module: dual output reset supervisor logic
//
// Behaviour
// - Either comparator low asserts system reset immediately
// - System reset holds 140 ms after both recover
// - Without extended setup, button never touches reset
// - Extended setup: long button hold asserts reset
// - Button-caused reset holds 140 ms after release
// - Button low pulls soft reset output immediately
// - Soft reset output holds 140 ms after release
// - Button input active low, undriven reads inactive
// - Outputs active low, push-pull or open-drain option
// - Setup period one of four factory options
`timescale 1ns/1ns
module drs_supervisor
    import drs_pkg::*;
#(
    parameter bit         EXT_SETUP   = 1'b1,               // Extended-setup variant
    parameter drs_setup_e SETUP_SEL   = DRS_SETUP_S,        // Factory setup option
    parameter bit         OPEN_DRAIN  = 1'b0,               // Drive style option
    parameter longint unsigned HOLD_CYC = TIMEOUT_CYC,      // Recovery timeout, cycles
    parameter longint unsigned SETUP_CYC_K = drs_setup_cyc(SETUP_K_MS),
    parameter longint unsigned SETUP_CYC_L = drs_setup_cyc(SETUP_L_MS),
    parameter longint unsigned SETUP_CYC_S = drs_setup_cyc(SETUP_S_MS),
    parameter longint unsigned SETUP_CYC_T = drs_setup_cyc(SETUP_T_MS)
) (
    input  wire logic clk,                                  // 250 MHz clock
    input  wire logic rst_n,                                // Async reset, active low
    input  wire logic vcc_under,                            // Primary comparator, high = low V
    input  wire logic aux_voltage_sense,                    // Adjustable comparator, high = ok
    input  wire logic manual_request_n,                     // Button, active low
    output logic      sys_reset_out_n,                      // System reset level
    output logic      sys_reset_oe,                         // System reset drive enable
    output logic      soft_reset_out_n,                     // Soft reset level
    output logic      soft_reset_oe                         // Soft reset drive enable
);

    // ------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_reg;                               // Reset release chain
    logic       rst_n_i;                                    // Internal reset
    drs_in_s    sync1_reg;                                  // First stage
    drs_in_s    sync2_reg;                                  // Second stage
    drs_in_s    raw_in;                                     // Pin levels, normalised

    // Release reset through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n_i = rst_sync_reg[1];

    // Undriven button reads high through pullup, so idle is inactive
    always_comb begin
        raw_in.vcc_low = vcc_under;
        raw_in.aux_low = ~aux_voltage_sense;
        raw_in.button  = ~manual_request_n;
    end

    // Two-flop synchroniser; reset state says supplies are low
    always_ff @(posedge clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg <= '{vcc_low: 1'b1, aux_low: 1'b1, button: 1'b0};
            sync2_reg <= '{vcc_low: 1'b1, aux_low: 1'b1, button: 1'b0};
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    // ------------------------------------------------------------
    // Extended setup selection and button hold counter
    // ------------------------------------------------------------
    logic [CNT_W-1:0] setup_cyc;                            // Selected setup count
    logic [CNT_W-1:0] press_cnt_reg;                        // Press duration
    logic [CNT_W-1:0] press_cnt_next;
    logic             long_press;                           // Held past setup

    // Pick one of four factory periods
    always_comb begin
        unique case (SETUP_SEL)
            DRS_SETUP_K: setup_cyc = CNT_W'(SETUP_CYC_K);
            DRS_SETUP_L: setup_cyc = CNT_W'(SETUP_CYC_L);
            DRS_SETUP_S: setup_cyc = CNT_W'(SETUP_CYC_S);
            DRS_SETUP_T: setup_cyc = CNT_W'(SETUP_CYC_T);
        endcase
    end

    // Count continuous press, saturate at setup period
    always_comb begin
        if (!sync2_reg.button) begin
            press_cnt_next = CNT_ZERO;                      // Release restarts count
        end else if (press_cnt_reg < setup_cyc) begin
            press_cnt_next = press_cnt_reg + CNT_ONE;
        end else begin
            press_cnt_next = press_cnt_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            press_cnt_reg <= CNT_ZERO;
        end else begin
            press_cnt_reg <= press_cnt_next;
        end
    end

    // Long press counts only in the extended-setup variant
    assign long_press = EXT_SETUP && sync2_reg.button &&
                        (press_cnt_reg >= setup_cyc);

    // ------------------------------------------------------------
    // System reset: cause and hold timer
    // ------------------------------------------------------------
    drs_state_e       sys_st_reg;
    drs_state_e       sys_st_next;
    logic [CNT_W-1:0] sys_cnt_reg;
    logic [CNT_W-1:0] sys_cnt_next;
    logic             sys_cause;                            // Any reason for reset
    logic             btn_hold_reg;                         // Reset latched by button
    logic             btn_hold_next;

    // Button-caused reset stays latched until the button is released
    always_comb begin
        if (long_press) begin
            btn_hold_next = 1'b1;
        end else if (!sync2_reg.button) begin
            btn_hold_next = 1'b0;                           // Timeout starts at release
        end else begin
            btn_hold_next = btn_hold_reg;
        end
    end

    assign sys_cause = sync2_reg.vcc_low || sync2_reg.aux_low ||
                       (EXT_SETUP && btn_hold_reg);

    // Active while cause, then hold for timeout, then idle
    always_comb begin
        sys_st_next  = sys_st_reg;
        sys_cnt_next = sys_cnt_reg;
        unique case (sys_st_reg)
            DRS_ACTIVE: begin
                sys_cnt_next = CNT_ZERO;
                if (!sys_cause) begin
                    sys_st_next = DRS_HOLD;
                end
            end
            DRS_HOLD: begin
                if (sys_cause) begin
                    sys_st_next  = DRS_ACTIVE;              // Cause returns, restart
                    sys_cnt_next = CNT_ZERO;
                end else if (sys_cnt_reg >= CNT_W'(HOLD_CYC - 1)) begin
                    sys_st_next = DRS_IDLE;
                end else begin
                    sys_cnt_next = sys_cnt_reg + CNT_ONE;
                end
            end
            DRS_IDLE: begin
                if (sys_cause) begin
                    sys_st_next = DRS_ACTIVE;
                end
            end
        endcase
    end

    // Power-up starts asserted
    always_ff @(posedge clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sys_st_reg   <= DRS_ACTIVE;
            sys_cnt_reg  <= CNT_ZERO;
            btn_hold_reg <= 1'b0;
        end else begin
            sys_st_reg   <= sys_st_next;
            sys_cnt_reg  <= sys_cnt_next;
            btn_hold_reg <= btn_hold_next;
        end
    end

    // ------------------------------------------------------------
    // Soft reset output: button and hold timer
    // ------------------------------------------------------------
    drs_state_e       soft_st_reg;
    drs_state_e       soft_st_next;
    logic [CNT_W-1:0] soft_cnt_reg;
    logic [CNT_W-1:0] soft_cnt_next;

    // Assert on press, hold for timeout after release
    always_comb begin
        soft_st_next  = soft_st_reg;
        soft_cnt_next = soft_cnt_reg;
        unique case (soft_st_reg)
            DRS_ACTIVE: begin
                soft_cnt_next = CNT_ZERO;
                if (!sync2_reg.button) begin
                    soft_st_next = DRS_HOLD;
                end
            end
            DRS_HOLD: begin
                if (sync2_reg.button) begin
                    soft_st_next  = DRS_ACTIVE;
                    soft_cnt_next = CNT_ZERO;
                end else if (soft_cnt_reg >= CNT_W'(HOLD_CYC - 1)) begin
                    soft_st_next = DRS_IDLE;
                end else begin
                    soft_cnt_next = soft_cnt_reg + CNT_ONE;
                end
            end
            DRS_IDLE: begin
                if (sync2_reg.button) begin
                    soft_st_next = DRS_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            soft_st_reg  <= DRS_IDLE;
            soft_cnt_reg <= CNT_ZERO;
        end else begin
            soft_st_reg  <= soft_st_next;
            soft_cnt_reg <= soft_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Output drive: push-pull or open-drain
    // ------------------------------------------------------------
    logic sys_low_next;                                     // Reset asserted next
    logic soft_low_next;

    assign sys_low_next  = (sys_st_next != DRS_IDLE);
    assign soft_low_next = (soft_st_next != DRS_IDLE);

    // Open-drain only drives while low; level stays low then
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_reset_out_n  <= 1'b0;
            sys_reset_oe     <= 1'b1;
            soft_reset_out_n <= OPEN_DRAIN ? 1'b0 : 1'b1;
            soft_reset_oe    <= ~OPEN_DRAIN;
        end else if (!rst_n_i) begin
            sys_reset_out_n  <= 1'b0;
            sys_reset_oe     <= 1'b1;
            soft_reset_out_n <= OPEN_DRAIN ? 1'b0 : 1'b1;
            soft_reset_oe    <= ~OPEN_DRAIN;
        end else begin
            sys_reset_out_n  <= OPEN_DRAIN ? 1'b0 : ~sys_low_next;
            sys_reset_oe     <= OPEN_DRAIN ? sys_low_next : 1'b1;
            soft_reset_out_n <= OPEN_DRAIN ? 1'b0 : ~soft_low_next;
            soft_reset_oe    <= OPEN_DRAIN ? soft_low_next : 1'b1;
        end
    end

endmodule

// ===== testbench/drs_asserts.sv
// Checker: port timing assertions for the reset supervisor
`timescale 1ns/1ns
module drs_asserts
    import drs_pkg::*;
#(
    parameter bit              EXT_SETUP  = 1'b1,
    parameter bit              OPEN_DRAIN = 1'b0,
    parameter longint unsigned HOLD_CYC   = 20,
    parameter longint unsigned SET_CYC    = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic vcc_under,
    input wire logic aux_voltage_sense,
    input wire logic manual_request_n,
    input wire logic sys_reset_out_n,
    input wire logic sys_reset_oe,
    input wire logic soft_reset_out_n,
    input wire logic soft_reset_oe
);
    // ----------------------------------------
    // Run-length counters
    // ----------------------------------------
    logic [31:0] good_reg, rel_reg, prs_reg;       // Supplies good, button up, button down
    logic [31:0] good_next, rel_next, prs_next;    // Next counts
    // Count consecutive cycles of each condition
    always_comb begin
        good_next = (vcc_under || !aux_voltage_sense) ? 32'h0 : good_reg + 32'h1;
        rel_next  = manual_request_n ? rel_reg + 32'h1 : 32'h0;
        prs_next  = manual_request_n ? 32'h0 : prs_reg + 32'h1;
    end
    // Register the counts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            good_reg <= 32'h0;
            rel_reg  <= 32'h0;
            prs_reg  <= 32'h0;
        end else begin
            good_reg <= good_next;
            rel_reg  <= rel_next;
            prs_reg  <= prs_next;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Host-side pin levels: an open-drain high comes from the pullup
    logic sys_lvl, soft_lvl;                       // Level seen by the host
    assign sys_lvl  = OPEN_DRAIN ? !sys_reset_oe : sys_reset_out_n;
    assign soft_lvl = OPEN_DRAIN ? !soft_reset_oe : soft_reset_out_n;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_vcc_low: assert property (
        vcc_under |-> ##[1:4] !sys_lvl) else $error("sys late after primary low");
    chk_aux_low: assert property (
        !aux_voltage_sense |-> ##[1:4] !sys_lvl) else $error("sys late after aux low");
    chk_sys_hold: assert property (
        $rose(sys_lvl) |-> good_reg >= HOLD_CYC && (!EXT_SETUP || rel_reg >= HOLD_CYC))
        else $error("sys released early");
    chk_sys_done: assert property (
        good_reg >= HOLD_CYC + 8 && (!EXT_SETUP || rel_reg >= HOLD_CYC + 8)
        |-> sys_lvl) else $error("sys held too long");
    chk_sys_cause: assert property (
        $fell(sys_lvl) |-> good_reg < 5 || (EXT_SETUP && (prs_reg >= SET_CYC
        || $past(prs_reg, 4) >= SET_CYC))) else $error("sys asserted without cause");
    chk_long_hard: assert property (
        EXT_SETUP && prs_reg == SET_CYC + 6 |-> !sys_lvl) else $error("no hard reset");
    chk_soft_fast: assert property (
        prs_reg == 32'h1 |-> ##[0:3] !soft_lvl) else $error("soft reset late");
    chk_soft_hold: assert property (
        $rose(soft_lvl) |-> rel_reg >= HOLD_CYC) else $error("soft released early");
    chk_soft_done: assert property (
        rel_reg == HOLD_CYC + 8 |-> soft_lvl) else $error("soft held too long");
    chk_drive_mode: assert property (
        OPEN_DRAIN ? (!sys_reset_out_n && !soft_reset_out_n)
        : (sys_reset_oe && soft_reset_oe)) else $error("drive enable wrong");
endmodule

bind drs_supervisor drs_asserts #(
    .EXT_SETUP (EXT_SETUP),
    .OPEN_DRAIN(OPEN_DRAIN),
    .HOLD_CYC  (HOLD_CYC),
    .SET_CYC   (SETUP_SEL == DRS_SETUP_K ? SETUP_CYC_K : SETUP_SEL == DRS_SETUP_L ?
                SETUP_CYC_L : SETUP_SEL == DRS_SETUP_S ? SETUP_CYC_S : SETUP_CYC_T)
) u_chk (
    .clk              (clk),
    .rst_n            (rst_n),
    .vcc_under        (vcc_under),
    .aux_voltage_sense(aux_voltage_sense),
    .manual_request_n (manual_request_n),
    .sys_reset_out_n  (sys_reset_out_n),
    .sys_reset_oe     (sys_reset_oe),
    .soft_reset_out_n (soft_reset_out_n),
    .soft_reset_oe    (soft_reset_oe)
);

// ===== testbench/drs_host_model.sv
// Partner: pushbutton with pullup and host view of both reset pins
`timescale 1ns/1ns
module drs_host_model (
    input  wire logic press,            // Button held
    input  wire logic sys_reset_out_n,  // Supervisor outputs
    input  wire logic sys_reset_oe,
    input  wire logic soft_reset_out_n,
    input  wire logic soft_reset_oe,
    output logic      manual_request_n, // Button line
    output logic      sys_pin,          // Host reset input
    output logic      soft_pin          // Host interrupt input
);
    // Open button reads high through the pullup
    assign manual_request_n = press ? 1'b0 : 1'b1;
    // Undriven pin floats up through the board pullup
    assign sys_pin  = sys_reset_oe ? sys_reset_out_n : 1'b1;
    assign soft_pin = soft_reset_oe ? soft_reset_out_n : 1'b1;
endmodule

// ===== testbench/testbench.sv
// Testbench: scenario tasks for the reset supervisor
`timescale 1ns/1ns
module testbench;
    import drs_pkg::*;
    localparam int HOLD  = 20;                      // Short recovery for sim
    localparam int SETUP = 20;                      // Selected setup option
    logic clk = 1'b0, rst_n = 1'b0, vcc_under = 1'b0, aux_ok = 1'b1, press = 1'b0;
    logic btn_n, a_sys_n, a_sys_oe, a_soft_n, a_soft_oe;   // Extended variant
    logic b_sys_n, b_sys_oe, b_soft_n, b_soft_oe;         // Plain open-drain variant
    logic a_sys, a_soft, b_sys, b_soft;                   // Pin levels
    logic c_sys;                                          // Shortest setup option
    int   n_mismatch = 0, comparisons = 0, cyc = 0;
    always #2 clk = ~clk;
    drs_supervisor #(.HOLD_CYC(HOLD), .SETUP_CYC_K(40), .SETUP_CYC_L(30),
        .SETUP_CYC_S(SETUP), .SETUP_CYC_T(10)) DUT (.clk(clk), .rst_n(rst_n),
        .vcc_under(vcc_under), .aux_voltage_sense(aux_ok), .manual_request_n(btn_n),
        .sys_reset_out_n(a_sys_n), .sys_reset_oe(a_sys_oe),
        .soft_reset_out_n(a_soft_n), .soft_reset_oe(a_soft_oe));
    drs_supervisor #(.EXT_SETUP(1'b0), .OPEN_DRAIN(1'b1), .HOLD_CYC(HOLD)) DUT2 (
        .clk(clk), .rst_n(rst_n), .vcc_under(vcc_under), .aux_voltage_sense(aux_ok),
        .manual_request_n(btn_n), .sys_reset_out_n(b_sys_n), .sys_reset_oe(b_sys_oe),
        .soft_reset_out_n(b_soft_n), .soft_reset_oe(b_soft_oe));
    drs_supervisor #(.SETUP_SEL(DRS_SETUP_T), .HOLD_CYC(HOLD), .SETUP_CYC_T(10)) DUT3 (
        .clk(clk), .rst_n(rst_n), .vcc_under(vcc_under), .aux_voltage_sense(aux_ok),
        .manual_request_n(btn_n), .sys_reset_out_n(c_sys), .sys_reset_oe(),
        .soft_reset_out_n(), .soft_reset_oe());
    drs_host_model M_A (.press(press), .sys_reset_out_n(a_sys_n), .sys_reset_oe(a_sys_oe),
        .soft_reset_out_n(a_soft_n), .soft_reset_oe(a_soft_oe), .manual_request_n(btn_n),
        .sys_pin(a_sys), .soft_pin(a_soft));
    drs_host_model M_B (.press(press), .sys_reset_out_n(b_sys_n), .sys_reset_oe(b_sys_oe),
        .soft_reset_out_n(b_soft_n), .soft_reset_oe(b_soft_oe), .manual_request_n(),
        .sys_pin(b_sys), .soft_pin(b_soft));
    // Advance n cycles, landing just after the edge
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic check(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic pin(input int s);
        return s == 0 ? a_sys : s == 1 ? a_soft : s == 2 ? b_sys : c_sys;
    endfunction
    // Pin must reach level v after lo to hi cycles
    task automatic expect_in(input int s, input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (pin(s) !== v && n <= hi) begin
            tick(1);
            n++;
        end
        check(pin(s), v);
        check(n >= lo && n <= hi, 1'b1);
    endtask
    task automatic t_powerup();
        check(a_sys, 1'b0);
        expect_in(0, 1'b1, HOLD, HOLD + 10);
        check(a_soft, 1'b1);
        $display("test powerup done");
    endtask
    // Brief dip on each supply in turn
    task automatic t_supply();
        for (int src = 0; src < 2; src++) begin
            if (src == 0) vcc_under = 1'b1;
            else aux_ok = 1'b0;
            tick(1);
            vcc_under = 1'b0;
            aux_ok = 1'b1;
            expect_in(0, 1'b0, 1, 4);
            check(b_sys, 1'b0);
            expect_in(0, 1'b1, HOLD - 2, HOLD + 8);
            expect_in(2, 1'b1, 0, 4);
        end
        $display("test supply done");
    endtask
    task automatic t_short_press();
        check(b_soft_oe, 1'b0);
        press = 1'b1;
        expect_in(1, 1'b0, 1, 4);
        check(b_soft, 1'b0);
        tick(SETUP - 10);
        check(a_sys, 1'b1);
        expect_in(3, 1'b0, 0, 4);
        press = 1'b0;
        expect_in(1, 1'b1, HOLD, HOLD + 8);
        check(a_sys, 1'b1);
        expect_in(3, 1'b1, 0, 4);
        $display("test short press done");
    endtask
    task automatic t_long_press();
        press = 1'b1;
        expect_in(0, 1'b0, SETUP, SETUP + 6);
        check(b_sys, 1'b1);
        tick(5);
        press = 1'b0;
        expect_in(0, 1'b1, HOLD, HOLD + 8);
        expect_in(1, 1'b1, 0, 4);
        $display("test long press done");
    endtask
    task automatic give_verdict();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        tick(4);
        rst_n = 1'b1;
        t_powerup();
        t_supply();
        t_short_press();
        t_long_press();
        give_verdict();
    end
endmodule
